//--- hw/pci_secondary_bus_arbiter.sv
// secondary PCI bus arbiter of the bridge: internal rotating arbiter or
// external arbiter by strap, general-purpose pins, interrupt lines, error
// line, clock fan-out, registers over AHB-Lite
// assumes one 100 MHz hclk, a single AHB-Lite master whose hready is this
// slave's hreadyout, and pads outside that resolve *_out/*_oe to wires
`timescale 1ns/1ns
`include "arb_defs.svh"

module pci_secondary_bus_arbiter
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic [7:0]  req_n_in,
    output logic      [7:0]  gnt_n_out,
    output logic      [7:0]  gnt_n_oe,
    input  wire logic        central_function_strap_n,
    input  wire logic        reverse_mode_strap,
    input  wire logic        irq_line_a_n_in,
    output logic             irq_line_a_n_out,
    output logic             irq_line_a_n_oe,
    input  wire logic        irq_line_b_n_in,
    output logic             irq_line_b_n_out,
    output logic             irq_line_b_n_oe,
    input  wire logic        irq_line_c_n_in,
    output logic             irq_line_c_n_out,
    output logic             irq_line_c_n_oe,
    input  wire logic        irq_line_d_n_in,
    output logic             irq_line_d_n_out,
    output logic             irq_line_d_n_oe,
    output logic             serr_n_out,
    output logic             serr_n_oe,
    output logic             park_drive_oe,
    input  wire logic        dly_write_discard,
    input  wire logic        dly_master_timeout,
    input  wire logic        adv_error_report,
    input  wire logic        transparent_mode,
    input  wire logic [3:0]  irq_event,
    input  wire logic        pci_clock_source,
    output logic      [8:0]  pci_clock_outputs
);
    import arb_pkg::*;

    // -------------------------------------------------------------------------
    // state and local signals
    // -------------------------------------------------------------------------
    top_regs_t         r;
    top_regs_t         n;
    logic [`SY_W-1:0]  sy;
    logic [3:0]        irq_in_n;
    logic [3:0]        irq_oe;
    logic [31:0]       ctrl_w;
    logic [31:0]       stat_w;
    logic              taken;
    logic              wr_now;
    logic [3:0]        irq_set;
    logic [3:0]        irq_clr;
    logic              serr_clr;
    logic              serr_evt;
    logic              ext_grant;
    logic [3:0]        general_input;

    arb_if ab ();

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    function automatic logic [31:0] sel_word(input logic [7:0]  addr,
                                             input logic [31:0] c_w,
                                             input logic [31:0] s_w,
                                             input logic [3:0]  pend);
        logic [31:0] w;
        w = `WORD_ZERO;
        if (hit(addr, `REG_CTRL))
            w = c_w;
        else if (hit(addr, `REG_IRQ_SET) || hit(addr, `REG_IRQ_CLR))
            w[`IRQ_LSB +: 4] = pend;
        else if (hit(addr, `REG_STATUS))
            w = s_w;
        return w;
    endfunction

    // -------------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------------
    assign irq_in_n = {irq_line_d_n_in, irq_line_c_n_in, irq_line_b_n_in, irq_line_a_n_in};

    // every pin-level input goes through two flops before any use
    sync2 #(.W(`SY_W)) u_sync
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .d       ({~irq_in_n, reverse_mode_strap, central_function_strap_n, ~req_n_in}),
        .q       (sy)
    );

    assign ext_grant = sy[0];
    assign general_input       = ~sy[5:2];

    // -------------------------------------------------------------------------
    // internal arbiter
    // -------------------------------------------------------------------------
    assign ab.req    = sy[7:0];
    assign ab.enable = r.strap_taken && !r.ext_mode;

    rr_arbiter u_arb
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .ab      (ab.arb)
    );

    // -------------------------------------------------------------------------
    // register views
    // -------------------------------------------------------------------------
    always_comb
    begin
        ctrl_w                            = `WORD_ZERO;
        ctrl_w[`CTRL_SERR_EN]             = r.serr_en;
        ctrl_w[`CTRL_OWN_REQ]             = r.own_req;
        ctrl_w[`CTRL_GPO_LSB +: 4]        = r.general_output;
        ctrl_w[`CTRL_CLK_LSB +: 9]        = r.clk_en;
        stat_w                            = `WORD_ZERO;
        stat_w[`ST_GNT_LSB +: 8]          = ab.gnt;
        stat_w[`ST_PARKED]                = ab.parked && ab.enable;
        stat_w[`ST_EXT_MODE]              = r.ext_mode;
        stat_w[`ST_EXT_GRANT]             = r.ext_mode && ext_grant;
        stat_w[`ST_REVERSE]               = r.reverse;
        stat_w[`ST_GPI_LSB +: 4]          = r.ext_mode ? general_input : 4'h0;
        stat_w[`ST_IRQ_IN_LSB +: 4]       = r.reverse ? 4'h0 : sy[`SY_IRQ_LSB +: 4];
        stat_w[`ST_IRQ_PEND_LSB +: 4]     = r.irq_pend;
        stat_w[`ST_SERR_PEND]             = r.serr_pend;
        stat_w[`ST_STRAP_DONE]            = r.strap_taken;
    end

    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    always_comb
    begin
        n        = r;
        irq_set  = 4'h0;
        irq_clr  = 4'h0;
        serr_clr = 1'b0;

        // AHB address phase; read data sampled now, presented in data phase
        taken      = hsel && hready && htrans[1];
        n.dp_valid = taken;
        if (taken)
        begin
            n.dp_write = hwrite;
            n.dp_addr  = haddr[`ADDR_W-1:0];
        end
        if (taken && !hwrite)
            n.rdata = sel_word(haddr[`ADDR_W-1:0], ctrl_w, stat_w, r.irq_pend);

        // AHB data phase writes; unmapped offsets are ignored
        wr_now = r.dp_valid && r.dp_write;
        if (wr_now && hit(r.dp_addr, `REG_CTRL))
        begin
            n.serr_en = hwdata[`CTRL_SERR_EN];
            n.own_req = hwdata[`CTRL_OWN_REQ];
            n.general_output     = hwdata[`CTRL_GPO_LSB +: 4];
            n.clk_en  = hwdata[`CTRL_CLK_LSB +: 9];
        end
        if (wr_now && hit(r.dp_addr, `REG_IRQ_SET))
            irq_set = hwdata[`IRQ_LSB +: 4];
        if (wr_now && hit(r.dp_addr, `REG_IRQ_CLR))
            irq_clr = hwdata[`IRQ_LSB +: 4];
        if (wr_now && hit(r.dp_addr, `REG_SERR_CLR))
            serr_clr = hwdata[`SERR_CLR_BIT];

        // strap is caught once, after the synchroniser has filled
        if (!r.strap_taken)
        begin
            if (r.strap_cnt == `STRAP_SETTLE)
            begin
                n.strap_taken = 1'b1;
                n.ext_mode    = sy[`SY_STRAP];
                n.reverse     = sy[`SY_REV];
            end
            else
            begin
                n.strap_cnt = r.strap_cnt + 2'h1;
            end
        end

        // sticky interrupts: a new event wins over a clear in the same cycle
        n.irq_pend = (r.irq_pend & ~irq_clr) | irq_set | irq_event;

        // system error: sticky while reporting is on, released when off
        serr_evt    = dly_write_discard || dly_master_timeout
                    || (adv_error_report && transparent_mode);
        n.serr_pend = r.serr_en && ((r.serr_pend && !serr_clr) || serr_evt);

        // grant pins and parking drive
        if (!r.strap_taken)
        begin
            n.gnt_n   = `GNT_N_IDLE;
            n.park_oe = 1'b0;
        end
        else if (r.ext_mode)
        begin
            n.gnt_n      = `GNT_N_IDLE;
            n.gnt_n[0]   = ~r.own_req;
            n.gnt_n[5:2] = r.general_output;
            n.park_oe    = ext_grant;
        end
        else
        begin
            n.gnt_n   = ~ab.gnt;
            n.park_oe = ab.parked;
        end
    end

    // -------------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r        <= '0;
            r.clk_en <= `CTRL_RST_CLK;
            r.gnt_n  <= `GNT_N_IDLE;
        end
        else if (ce)
        begin
            r <= n;
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    // bus never waits and never errors: every register answers in one cycle
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = r.rdata;

    // enables gate on the reset pin itself, so pins float with no clock edge
    assign gnt_n_out     = r.gnt_n;
    assign gnt_n_oe      = {8{hresetn}};
    assign park_drive_oe = hresetn && r.park_oe;
    assign serr_n_out    = 1'b0;
    assign serr_n_oe     = hresetn && r.serr_pend;

    // open drain: only ever pull low, and only in reverse mode
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_irq
            assign irq_oe[gi] = hresetn && r.reverse && r.irq_pend[gi];
        end
    endgenerate

    assign irq_line_a_n_out = 1'b0;
    assign irq_line_b_n_out = 1'b0;
    assign irq_line_c_n_out = 1'b0;
    assign irq_line_d_n_out = 1'b0;
    assign irq_line_a_n_oe  = irq_oe[0];
    assign irq_line_b_n_oe  = irq_oe[1];
    assign irq_line_c_n_oe  = irq_oe[2];
    assign irq_line_d_n_oe  = irq_oe[3];

    // plain gating of the source clock; glitch-free gating is left to the
    // pad cell library, trading a clean stop edge for a small fan-out
    assign pci_clock_outputs = {9{pci_clock_source}} & r.clk_en;

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking tcb @(posedge hclk); endclocking
    default disable iff (!hresetn || !ce);

    sequence serr_raise;
        r.serr_en && serr_evt;
    endsequence

    sequence serr_held;
        (serr_n_oe && !serr_clr && r.serr_en)[*2];
    endsequence

    AST_RESET_FLOAT: assert property (@(posedge hclk) disable iff (1'b0)
        !hresetn |-> (gnt_n_oe == 8'h00) && !park_drive_oe && !serr_n_oe && (irq_oe == 4'h0))
        else $error("pin driven during reset");
    AST_SERR_SET: assert property (serr_raise |=> serr_n_oe && !serr_n_out)
        else $error("error event not reported");
    AST_SERR_OFF: assert property (!r.serr_en |=> !serr_n_oe)
        else $error("error line driven while reporting is off");
    AST_SERR_STICK: assert property (serr_held |=> serr_n_oe)
        else $error("error line dropped without clear");
    AST_IRQ_STICK: assert property ((r.irq_pend[0] && !irq_clr[0]) |=> r.irq_pend[0])
        else $error("interrupt dropped without clear");
    AST_IRQ_DIR: assert property (!r.reverse |-> (irq_oe == 4'h0))
        else $error("interrupt line driven in forward mode");
    AST_IRQ_OD: assert property ((r.reverse && r.irq_pend[1]) |->
        irq_line_b_n_oe && !irq_line_b_n_out)
        else $error("pending interrupt not pulled low");
    AST_EXT_PINS: assert property ((r.strap_taken && r.ext_mode) |=>
        (gnt_n_out[5:2] == $past(r.general_output)) && (gnt_n_out[0] == !$past(r.own_req)))
        else $error("external mode grant pins wrong");
    AST_INT_GNT: assert property ((r.strap_taken && !r.ext_mode) |=>
        (gnt_n_out == ~$past(ab.gnt)))
        else $error("grant pins do not follow arbiter");
    AST_CLK_OUT: assert property ((r.clk_en[0] && pci_clock_source) |->
        pci_clock_outputs[0])
        else $error("clock output not following source");

endmodule // pci_secondary_bus_arbiter

//--- include/arb_defs.svh
// register map, field positions, reset values and counts of the
// secondary bus arbiter; assumes 32-bit AHB-Lite words, byte addresses
`ifndef ARB_DEFS_SVH
`define ARB_DEFS_SVH

// -----------------------------------------------------------------------------
// register offsets (byte addresses, low 8 address bits decoded)
// -----------------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_IRQ_SET     8'h04
`define REG_IRQ_CLR     8'h08
`define REG_STATUS      8'h0C
`define REG_SERR_CLR    8'h10
`define ADDR_W          8

// -----------------------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------------------
`define CTRL_SERR_EN    0
`define CTRL_OWN_REQ    1
`define CTRL_GPO_LSB    4
`define CTRL_CLK_LSB    8
`define CTRL_RST_CLK    9'h1FF
`define IRQ_LSB         0
`define SERR_CLR_BIT    0

// -----------------------------------------------------------------------------
// status register fields
// -----------------------------------------------------------------------------
`define ST_GNT_LSB      0
`define ST_PARKED       8
`define ST_EXT_MODE     9
`define ST_EXT_GRANT    10
`define ST_REVERSE      11
`define ST_GPI_LSB      12
`define ST_IRQ_IN_LSB   16
`define ST_IRQ_PEND_LSB 20
`define ST_SERR_PEND    24
`define ST_STRAP_DONE   25

// -----------------------------------------------------------------------------
// synchroniser lanes, reset values, counts
// -----------------------------------------------------------------------------
`define SY_W            14
`define SY_STRAP        8
`define SY_REV          9
`define SY_IRQ_LSB      10
`define STRAP_SETTLE    2'h2
`define GNT_N_IDLE      8'hFF
`define GNT_NONE        8'h00
`define ONE_HOT_BASE    8'h01
`define ARB_LAST_RST    3'h7
`define WORD_ZERO       32'h0000_0000

`endif

//--- include/arb_pkg.sv
// types shared by the secondary bus arbiter modules
// assumes nothing of its surroundings
package arb_pkg;

    typedef enum logic [1:0] {
        ARB_PARK  = 2'b00,
        ARB_GRANT = 2'b01,
        ARB_GAP   = 2'b10
    } arb_state_t;

    typedef struct packed {
        arb_state_t  st;
        logic [2:0]  last;
        logic [2:0]  owner;
        logic [7:0]  gnt;
    } arb_regs_t;

    typedef struct packed {
        logic        serr_en;
        logic        own_req;
        logic [3:0]  general_output;
        logic [8:0]  clk_en;
        logic [3:0]  irq_pend;
        logic        serr_pend;
        logic [1:0]  strap_cnt;
        logic        strap_taken;
        logic        ext_mode;
        logic        reverse;
        logic        dp_valid;
        logic        dp_write;
        logic [7:0]  dp_addr;
        logic [31:0] rdata;
        logic [7:0]  gnt_n;
        logic        park_oe;
    } top_regs_t;

endpackage

//--- include/arb_if.sv
// request/grant carrier between the top and the rotating arbiter
// assumes both ends run on hclk; requests active high, already synchronised
`timescale 1ns/1ns

interface arb_if;
    logic [7:0] req;
    logic       enable;
    logic [7:0] gnt;
    logic       parked;

    modport arb (input req, input enable, output gnt, output parked);
    modport ctl (output req, output enable, input gnt, input parked);
endinterface

//--- hw/sync2.sv
// two-flop level synchroniser for pins arriving from outside hclk
// assumes levels, not pulses; a pulse shorter than one clock may be missed
`timescale 1ns/1ns

module sync2
#(
    parameter int W = 1
)
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_regs_t;

    sync_regs_t r;
    sync_regs_t n;

    always_comb
    begin
        n    = r;
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            r <= '0;
        else if (ce)
            r <= n;
    end

    assign q = r.s2;

endmodule // sync2

//--- hw/rr_arbiter.sv
// rotating-priority arbiter for the eight secondary bus masters
// assumes requests synchronised to hclk and active high
`timescale 1ns/1ns
`include "arb_defs.svh"

module rr_arbiter
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    arb_if.arb        ab
);
    import arb_pkg::*;

    arb_regs_t  r;
    arb_regs_t  n;
    logic [3:0] win;

    // last owner gets lowest priority: scanned first, overwritten by nearer
    function automatic logic [3:0] pick(input logic [7:0] req, input logic [2:0] last);
        logic [3:0] res;
        logic [2:0] idx;
        res = 4'h0;
        for (int k = 8; k >= 1; k--)
        begin
            idx = last + 3'(k);
            if (req[idx])
                res = {1'b1, idx};
        end
        return res;
    endfunction

    always_comb
    begin
        n   = r;
        win = pick(ab.req, r.last);
        case (r.st)
            ARB_PARK, ARB_GAP:
            begin
                if (ab.enable && win[3])
                begin
                    n.st    = ARB_GRANT;
                    n.owner = win[2:0];
                    n.gnt   = `ONE_HOT_BASE << win[2:0];
                end
                else
                begin
                    n.st = ARB_PARK;
                end
            end
            ARB_GRANT:
            begin
                if (!ab.enable || !ab.req[r.owner])
                begin
                    n.st   = ARB_GAP;
                    n.gnt  = `GNT_NONE;
                    n.last = r.owner;
                end
            end
            default:
            begin
                n.st  = ARB_PARK;
                n.gnt = `GNT_NONE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            r <= '{st: ARB_PARK, last: `ARB_LAST_RST, owner: `ARB_LAST_RST, gnt: `GNT_NONE};
        else if (ce)
            r <= n;
    end

    assign ab.gnt    = r.gnt;
    assign ab.parked = (r.st == ARB_PARK);

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking acb @(posedge hclk); endclocking
    default disable iff (!hresetn || !ce);

    sequence grant_released;
        (ab.gnt != `GNT_NONE) ##1 (ab.gnt == `GNT_NONE);
    endsequence

    AST_ONE_GRANT: assert property ($onehot0(ab.gnt))
        else $error("more than one grant");
    AST_SWITCH_GAP: assert property ((ab.gnt != `GNT_NONE) |=>
        (ab.gnt == $past(ab.gnt)) || (ab.gnt == `GNT_NONE))
        else $error("grant moved without an idle clock");
    AST_GRANT_HAS_REQ: assert property ((ab.gnt != `GNT_NONE) |->
        (($past(ab.req) & ab.gnt) != `GNT_NONE))
        else $error("grant without request");
    AST_PARK_IDLE: assert property (ab.parked |-> (ab.gnt == `GNT_NONE))
        else $error("parked with a grant out");
    AST_ROTATE: assert property ((grant_released ##0 ab.enable
        ##0 ((ab.req & ~(`ONE_HOT_BASE << r.last)) != `GNT_NONE))
        |=> (ab.gnt != `GNT_NONE) && ((ab.gnt & (`ONE_HOT_BASE << $past(r.last))) == `GNT_NONE))
        else $error("released master regranted ahead of others");

endmodule // rr_arbiter

//--- verif/bus_masters.sv
// the eight secondary bus masters pulling their request lines
// assumes the bench's hclk; want is one level per master
`timescale 1ns/1ns

module bus_masters
(
    input  wire logic       hclk,
    input  wire logic [7:0] want,
    output logic      [7:0] req_n
);
    logic [1:0] gap [8] = '{default: 2'h0};

    initial req_n = 8'hFF;

    always @(posedge hclk)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (gap[i] != 2'h0)
                gap[i] <= gap[i] - 2'h1;
            else if (want[i] && req_n[i])
                req_n[i] <= 1'b0;
            if (!want[i] && !req_n[i])
            begin
                req_n[i] <= 1'b1;
                gap[i]   <= 2'h2;
            end
        end
    end
endmodule // bus_masters

//--- verif/pci_secondary_bus_arbiter_tb_top.sv
// bench: register tasks, arbitration, error line, interrupts, ext mode
// assumes design files and bus_masters compiled before it
`timescale 1ns/1ns
`include "arb_defs.svh"

module pci_secondary_bus_arbiter_tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [7:0]  want = 8'h00;
    logic [3:0]  irq_in_n = 4'hA;
    logic [3:0]  irq_ev = 4'h0;
    logic [2:0]  evt = 3'h0;
    logic        strap = 1'b0;
    logic        rev = 1'b0;
    logic        tm = 1'b1;
    logic        src = 1'b0;
    logic [31:0] hrdata, q;
    logic [7:0]  req_n, gnt_n_out, gnt_n_oe;
    logic [8:0]  clk_out;
    logic        hreadyout, hresp, serr_oe, park_oe;
    logic [3:0]  irq_oe, irq_out;
    int          mismatches = 0;
    int          num_checks = 0;

    always #5 hclk = ~hclk;

    bus_masters bus_masters_inst (.hclk, .want, .req_n);

    pci_secondary_bus_arbiter pci_secondary_bus_arbiter_inst (
        .hclk, .hresetn, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .req_n_in(req_n), .gnt_n_out, .gnt_n_oe, .central_function_strap_n(strap),
        .reverse_mode_strap(rev), .irq_line_a_n_in(irq_in_n[0]),
        .irq_line_b_n_in(irq_in_n[1]), .irq_line_c_n_in(irq_in_n[2]),
        .irq_line_d_n_in(irq_in_n[3]), .irq_line_a_n_out(irq_out[0]),
        .irq_line_b_n_out(irq_out[1]), .irq_line_c_n_out(irq_out[2]),
        .irq_line_d_n_out(irq_out[3]), .irq_line_a_n_oe(irq_oe[0]),
        .irq_line_b_n_oe(irq_oe[1]), .irq_line_c_n_oe(irq_oe[2]),
        .irq_line_d_n_oe(irq_oe[3]),
        .serr_n_out(), .serr_n_oe(serr_oe), .park_drive_oe(park_oe),
        .dly_write_discard(evt[0]), .dly_master_timeout(evt[1]),
        .adv_error_report(evt[2]), .transparent_mode(tm), .irq_event(irq_ev),
        .pci_clock_source(src), .pci_clock_outputs(clk_out));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one idle edge after each transfer so a read never sees stale data
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        @(posedge hclk);
    endtask

    task automatic wait_gnt(input logic [7:0] exp);
        int n = 0;
        while (gnt_n_out !== exp && n < 40)
        begin
            @(posedge hclk);
            n++;
        end
        check(32'(gnt_n_out), 32'(exp));
    endtask

    task automatic pulse(input logic [2:0] e, input logic exp);
        evt <= e;
        @(posedge hclk);
        evt <= 3'h0;
        @(posedge hclk);
        check(32'(serr_oe), 32'(exp));
        xfer(1'b1, `REG_SERR_CLR, 32'h0000_0001);
        check(32'(serr_oe), 32'h0000_0000);
    endtask

    task automatic do_reset(input logic s, input logic r);
        hresetn <= 1'b0;
        strap   <= s;
        rev     <= r;
        repeat (16) @(posedge hclk);
        check(32'({gnt_n_oe, serr_oe, irq_oe, park_oe}), 32'h0000_0000);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask

    task automatic results();
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        do_reset(1'b0, 1'b0);
        xfer(1'b0, `REG_STATUS, 32'h0000_0000);
        check(q, 32'h0205_0100);
        check(32'(park_oe), 32'h0000_0001);
        src <= 1'b1;
        @(posedge hclk);
        check(32'(clk_out), 32'h0000_01FF);
        want <= 8'h08;
        wait_gnt(8'hF7);
        check(32'(park_oe), 32'h0000_0000);
        want <= 8'h2A;
        repeat (8) @(posedge hclk);
        check(32'(gnt_n_out), 32'h0000_00F7);
        want <= 8'h22;
        wait_gnt(8'hFF);
        wait_gnt(8'hDF);
        want <= 8'h00;
        wait_gnt(8'hFF);
        xfer(1'b1, `REG_CTRL, 32'h0001_FF01);
        for (int i = 0; i < 3; i++)
            pulse(3'(1 << i), 1'b1);
        // express errors count only in transparent mode
        tm <= 1'b0;
        pulse(3'h4, 1'b0);
        xfer(1'b1, `REG_CTRL, 32'h0000_AA00);
        pulse(3'h7, 1'b0);
        check(32'(clk_out), 32'h0000_00AA);
        xfer(1'b1, `REG_IRQ_SET, 32'h0000_0005);
        irq_ev <= 4'h8;
        @(posedge hclk);
        irq_ev <= 4'h0;
        repeat (20) @(posedge hclk);
        xfer(1'b0, `REG_IRQ_CLR, 32'h0000_0000);
        check(q, 32'h0000_000D);
        check(32'(irq_oe), 32'h0000_0000);
        xfer(1'b1, `REG_IRQ_CLR, 32'h0000_000D);
        xfer(1'b0, `REG_IRQ_SET, 32'h0000_0000);
        check(q, 32'h0000_0000);
        do_reset(1'b1, 1'b1);
        want <= 8'h15;
        xfer(1'b1, `REG_CTRL, 32'h0001_FFA2);
        xfer(1'b1, `REG_IRQ_SET, 32'h0000_0003);
        xfer(1'b0, `REG_STATUS, 32'h0000_0000);
        check(q, 32'h0230_AE00);
        check(32'(gnt_n_out), 32'h0000_00EA);
        check(32'(park_oe), 32'h0000_0001);
        check(32'({irq_out, irq_oe}), 32'h0000_0003);
        results();
    end

    // run takes about 1500 ns; this cuts a hang short
    initial
    begin
        #100000;
        mismatches++;
        results();
    end
endmodule // pci_secondary_bus_arbiter_tb_top
